// File: verilog/isd_params.svh
// constants for the two-wire slave with address recognition and dma
`ifndef ISD_PARAMS_SVH
`define ISD_PARAMS_SVH
`define ISD_GC_ADDR   8'h00
`define ISD_START_BYTE 8'h01
`define ISD_TEN_HDR   5'h1E
`define ISD_LAST_BIT  3'h7
`define ISD_BIT_ZERO  3'h0
`define ISD_BIT_ONE   3'h1
`define ISD_FIFO_DEPTH 8
`define ISD_BYTE_W    8
`endif

// File: verilog/isd_pkg.sv
// types shared by the slave controller files
package isd_pkg;
	typedef logic [7:0] isd_byte_t;
	typedef logic [9:0] isd_addr_t;
	typedef enum {
		ST_IDLE,
		ST_RX,
		ST_BYTE_END,
		ST_EVAL,
		ST_ACK,
		ST_TX_LOAD,
		ST_TX,
		ST_TX_ACK,
		ST_HOLD
	} isd_state_e;
endpackage

// File: verilog/isd_line_sync.sv
// synchroniser and edge, start and stop detection for the bus lines
`timescale 1ns/100ps
module isd_line_sync
(
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic sclIn,
	input  wire logic sdaIn,
	output logic      sclS,
	output logic      sdaS,
	output logic      sclRise,
	output logic      sclFall,
	output logic      startSeen,
	output logic      stopSeen
);
	logic [1:0] sclMeta_q;
	logic [1:0] sdaMeta_q;
	logic       sclPrev_q;
	logic       sdaPrev_q;

	// =====================================================
	// two flops per line; only the second stage is used
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sclMeta_q <= 2'h3;
			sdaMeta_q <= 2'h3;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end
		else
		begin
			sclMeta_q <= {sclMeta_q[0], sclIn};
			sdaMeta_q <= {sdaMeta_q[0], sdaIn};
			sclPrev_q <= sclMeta_q[1];
			sdaPrev_q <= sdaMeta_q[1];
		end
	end

	assign sclS      = sclMeta_q[1];
	assign sdaS      = sdaMeta_q[1];
	assign sclRise   = sclS && !sclPrev_q;
	assign sclFall   = !sclS && sclPrev_q;
	// data moving while the clock is high marks a frame edge
	assign startSeen = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign stopSeen  = sclS && sclPrev_q && !sdaPrev_q && sdaS;
endmodule // isd_line_sync

// File: verilog/isd_fifo.sv
// received byte buffer with valid and ready on both sides
`timescale 1ns/100ps
module isd_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             doPush;
	logic             doPop;

	assign inReady  = count_q != (AW+1)'(DEPTH);
	assign outValid = count_q != '0;
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;
	assign outData  = mem[rdPtr_q];

	// =====================================================
	always_ff @(posedge core_clk)
	begin
		if (doPush)
			mem[wrPtr_q] <= inData;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			if (doPop)
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end
endmodule // isd_fifo

// File: verilog/isd_slave.sv
// two-wire slave: address recognition, receive, transmit, dma routing
// =====================================================
// Notes on behaviour
// - hardware matches programmed 7-bit or 10-bit own address
// - address ack driven from refuse-ack bit
// - general call or start byte sets flags
// - all-zero address: write general call, read start
// - start byte is never acknowledged under hardware recognition
// - soft recognition: every byte raises receive interrupt, or dma request when routed
// - soft recognition stretches clock until control write
// - soft recognition sets only the direction flag
// - own write address: ack, match, clear direction
// - status read clears address-match flag
// - each data byte acked per bit, sets full
// - data read pops one byte; receive-full clears when buffer empties
// - dma routing moves each received byte onward
// - stop or restart after an acked address sets flag and interrupt
// - master refusing sent byte raises interrupt
`timescale 1ns/100ps
`include "isd_params.svh"
module isd_slave
#(
	parameter int FIFO_DEPTH = `ISD_FIFO_DEPTH
)
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              sclIn,
	output logic                   sclOut,
	output logic                   sclOe,
	input  wire logic              sdaIn,
	output logic                   sdaOut,
	output logic                   sdaOe,
	input  wire logic              controllerEnable,
	input  wire logic              tenBitMode,
	input  wire logic              softwareRecognitionSelect,
	input  wire logic              generalCallEnable,
	input  wire logic              dmaRoutingFlag,
	input  wire logic              refuseAck,
	input  wire isd_pkg::isd_addr_t ownAddressField,
	input  wire logic              controlWrite,
	input  wire logic              statusRead,
	output isd_pkg::isd_byte_t     rxData,
	output logic                   receiveFullFlag,
	input  wire logic              dataRead,
	output logic                   dmaRequest,
	input  wire isd_pkg::isd_byte_t txData,
	input  wire logic              txValid,
	output logic                   txReady,
	output logic                   addressMatchFlag,
	output logic                   generalCallFlag,
	output logic                   readDirFlag,
	output logic                   stopRestartFlag,
	output logic                   refusedAckFlag,
	output logic                   irq
);
	import isd_pkg::*;

	isd_state_e state_q;
	isd_state_e next_q;
	isd_byte_t  shift_q;
	logic [2:0] bitCnt_q;
	logic       addrPhase_q;
	logic       tenPend_q;
	logic       tenMatched_q;
	logic       addressed_q;
	logic       nak_q;
	logic       pushDone_q;
	logic       ctlSeen_q;
	logic       masterNack_q;
	logic       addressMatchFlag_q;
	logic       generalCallFlag_q;
	logic       readDirFlag_q;
	logic       stopRestartFlag_q;
	logic       refusedAckFlag_q;
	logic       sclS;
	logic       sdaS;
	logic       sclRise;
	logic       sclFall;
	logic       startSeen;
	logic       stopSeen;
	logic       fifoInValid;
	logic       fifoInReady;
	logic       rxValid;
	logic       hw;
	logic       rw;
	logic       isGc;
	logic       isSb;
	logic       is7;
	logic       isTenHdr;
	logic       isTen2;
	logic       hwWrite;
	logic       hwRead;
	logic       hwTenStep;
	logic       pushNeed;
	logic       evalGo;
	logic       samSet;
	logic       gcaSet;
	logic       evalNak;
	isd_state_e evalNext;

	// =====================================================
	// line conditioning
	isd_line_sync u_sync
	(
		.core_clk  (core_clk),
		.nrst      (nrst),
		.sclIn     (sclIn),
		.sdaIn     (sdaIn),
		.sclS      (sclS),
		.sdaS      (sdaS),
		.sclRise   (sclRise),
		.sclFall   (sclFall),
		.startSeen (startSeen),
		.stopSeen  (stopSeen)
	);

	// =====================================================
	// receive buffer; full buffer stretches the clock
	isd_fifo #(.WIDTH(`ISD_BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.core_clk (core_clk),
		.nrst     (nrst),
		.inData   (shift_q),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.outData  (rxData),
		.outValid (rxValid),
		.outReady (dataRead)
	);

	// =====================================================
	// address decode of the byte just shifted in
	assign hw = !softwareRecognitionSelect;
	assign rw = shift_q[0];
	assign isGc = generalCallEnable && addrPhase_q && !tenPend_q
		&& shift_q == `ISD_GC_ADDR;
	assign isSb = generalCallEnable && addrPhase_q && !tenPend_q
		&& shift_q == `ISD_START_BYTE;
	assign is7 = !tenBitMode && addrPhase_q && !tenPend_q
		&& shift_q[7:1] == ownAddressField[6:0];
	// ten-bit header then low byte compare
	assign isTenHdr = tenBitMode && addrPhase_q && !tenPend_q
		&& shift_q[7:3] == `ISD_TEN_HDR
		&& shift_q[2:1] == ownAddressField[9:8];
	assign isTen2 = tenPend_q && shift_q == ownAddressField[7:0];
	assign hwWrite = (is7 && !rw) || isTen2 || isGc;
	assign hwRead = (is7 && rw) || (isTenHdr && rw && tenMatched_q);
	assign hwTenStep = isTenHdr && !rw;

	// in soft mode every byte goes to the buffer
	assign pushNeed = softwareRecognitionSelect || !addrPhase_q;
	assign fifoInValid = state_q == ST_EVAL && pushNeed && !pushDone_q;
	// soft mode waits for the control write
	assign evalGo = state_q == ST_EVAL
		&& (!pushNeed || pushDone_q || fifoInReady)
		&& (hw || ctlSeen_q || controlWrite);

	always_comb
	begin
		samSet   = 1'b0;
		gcaSet   = 1'b0;
		evalNak  = 1'b1;
		evalNext = ST_HOLD;
		if (!hw)
		begin
			evalNak = refuseAck;
			if (!refuseAck)
				evalNext = (addrPhase_q && rw) ? ST_TX_LOAD : ST_RX;
		end
		else if (!addrPhase_q)
		begin
			evalNak = refuseAck;
			evalNext = refuseAck ? ST_HOLD : ST_RX;
		end
		else if (isSb)
		begin
			samSet = 1'b1;
			gcaSet = 1'b1;
		end
		else if (hwTenStep)
		begin
			evalNak = refuseAck;
			evalNext = refuseAck ? ST_HOLD : ST_RX;
		end
		else if (hwWrite || hwRead)
		begin
			samSet = 1'b1;
			gcaSet = isGc;
			evalNak = refuseAck;
			if (!refuseAck)
				evalNext = hwRead ? ST_TX_LOAD : ST_RX;
		end
	end

	// =====================================================
	// bus sequencing
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q      <= ST_IDLE;
			next_q       <= ST_IDLE;
			shift_q      <= '0;
			bitCnt_q     <= `ISD_BIT_ZERO;
			addrPhase_q  <= 1'b0;
			tenPend_q    <= 1'b0;
			tenMatched_q <= 1'b0;
			addressed_q  <= 1'b0;
			nak_q        <= 1'b1;
			masterNack_q <= 1'b0;
		end
		else if (!controllerEnable || stopSeen)
		begin
			state_q      <= ST_IDLE;
			addressed_q  <= 1'b0;
			tenMatched_q <= 1'b0;
		end
		else if (startSeen)
		begin
			state_q     <= ST_RX;
			bitCnt_q    <= `ISD_BIT_ZERO;
			addrPhase_q <= 1'b1;
			tenPend_q   <= 1'b0;
			addressed_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_RX:
					if (sclRise)
					begin
						shift_q  <= {shift_q[6:0], sdaS};
						bitCnt_q <= bitCnt_q + `ISD_BIT_ONE;
						if (bitCnt_q == `ISD_LAST_BIT)
							state_q <= ST_BYTE_END;
					end
				ST_BYTE_END:
					if (sclFall)
						state_q <= ST_EVAL;
				ST_EVAL:
					if (evalGo)
					begin
						nak_q   <= evalNak;
						next_q  <= evalNext;
						state_q <= ST_ACK;
						if (hw && addrPhase_q)
						begin
							tenPend_q <= hwTenStep && !refuseAck;
							if (isTen2)
								tenMatched_q <= 1'b1;
							if (!hwTenStep)
								addrPhase_q <= 1'b0;
						end
						else
							addrPhase_q <= 1'b0;
						if (evalNext != ST_HOLD)
							addressed_q <= 1'b1;
					end
				ST_ACK:
					if (sclFall)
					begin
						state_q  <= next_q;
						bitCnt_q <= `ISD_BIT_ZERO;
					end
				ST_TX_LOAD:
					if (txValid)
					begin
						shift_q  <= txData;
						bitCnt_q <= `ISD_BIT_ZERO;
						state_q  <= ST_TX;
					end
				ST_TX:
					if (sclFall)
					begin
						shift_q  <= {shift_q[6:0], 1'b1};
						bitCnt_q <= bitCnt_q + `ISD_BIT_ONE;
						if (bitCnt_q == `ISD_LAST_BIT)
							state_q <= ST_TX_ACK;
					end
				ST_TX_ACK:
				begin
					if (sclRise)
						masterNack_q <= sdaS;
					if (sclFall)
						state_q <= masterNack_q ? ST_HOLD : ST_TX_LOAD;
				end
				default:
					state_q <= state_q;
			endcase
		end
	end

	// one push per received byte, one control write per soft decision
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pushDone_q <= 1'b0;
			ctlSeen_q  <= 1'b0;
		end
		else if (state_q != ST_EVAL || evalGo)
		begin
			pushDone_q <= 1'b0;
			ctlSeen_q  <= 1'b0;
		end
		else
		begin
			if (fifoInValid && fifoInReady)
				pushDone_q <= 1'b1;
			if (controlWrite)
				ctlSeen_q <= 1'b1;
		end
	end

	// =====================================================
	// status flags; a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			addressMatchFlag_q <= 1'b0;
			generalCallFlag_q  <= 1'b0;
			readDirFlag_q      <= 1'b0;
			stopRestartFlag_q  <= 1'b0;
			refusedAckFlag_q   <= 1'b0;
		end
		else
		begin
			// status read clears the match flag
			if (evalGo && samSet)
				addressMatchFlag_q <= 1'b1;
			else if (statusRead)
				addressMatchFlag_q <= 1'b0;
			// general call and start byte mark the flag
			if (evalGo && gcaSet)
				generalCallFlag_q <= 1'b1;
			else if (statusRead)
				generalCallFlag_q <= 1'b0;
			// direction still follows the first address byte
			if (evalGo && addrPhase_q && !tenPend_q)
				readDirFlag_q <= rw;
			if ((startSeen || stopSeen) && addressed_q)
				stopRestartFlag_q <= 1'b1;
			else if (statusRead)
				stopRestartFlag_q <= 1'b0;
			if (state_q == ST_TX_ACK && sclRise && sdaS)
				refusedAckFlag_q <= 1'b1;
			else if (statusRead)
				refusedAckFlag_q <= 1'b0;
		end
	end

	// =====================================================
	// pins and outputs; the lines are only ever pulled low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	// clock held low while the block decides
	assign sclOe = state_q == ST_EVAL
		|| (state_q == ST_TX_LOAD && !txValid);
	assign sdaOe = (state_q == ST_ACK && !nak_q)
		|| (state_q == ST_TX && !shift_q[7]);
	assign txReady = state_q == ST_TX_LOAD;
	// the buffer pop is the data read
	assign receiveFullFlag = rxValid;
	// routed bytes leave through the dma request
	assign dmaRequest = rxValid && dmaRoutingFlag;
	// routing suppresses only the data interrupt
	assign irq = addressMatchFlag_q || stopRestartFlag_q
		|| refusedAckFlag_q || (rxValid && !dmaRoutingFlag);
	assign addressMatchFlag = addressMatchFlag_q;
	assign generalCallFlag  = generalCallFlag_q;
	assign readDirFlag      = readDirFlag_q;
	assign stopRestartFlag  = stopRestartFlag_q;
	assign refusedAckFlag   = refusedAckFlag_q;

	// =====================================================
	// checks
	a_ten_match: assert property (@(posedge core_clk) disable iff (!nrst)
		evalGo && hw && isTen2 |=> addressMatchFlag_q && !readDirFlag_q)
		else $error("ten-bit match did not set the flag");
	a_addr_ack_bit: assert property (@(posedge core_clk) disable iff (!nrst)
		evalGo && hw && hwWrite ##1 state_q == ST_ACK |->
		nak_q == $past(refuseAck))
		else $error("address ack not taken from refuse-ack");
	a_gc_flags: assert property (@(posedge core_clk) disable iff (!nrst)
		evalGo && hw && isGc |=> generalCallFlag_q && !readDirFlag_q)
		else $error("general call flags wrong");
	a_sb_refused: assert property (@(posedge core_clk) disable iff (!nrst)
		evalGo && hw && isSb |=> nak_q && !sdaOe && next_q == ST_HOLD)
		else $error("start byte acknowledged");
	a_soft_stretch: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == ST_EVAL && !hw && !ctlSeen_q && !controlWrite |->
		sclOe ##1 (state_q == ST_EVAL || stopSeen || startSeen
		|| !$past(controllerEnable)))
		else $error("soft mode released the clock early");
	a_soft_no_sam: assert property (@(posedge core_clk) disable iff (!nrst)
		evalGo && !hw && !statusRead && addrPhase_q |=>
		addressMatchFlag_q == $past(addressMatchFlag_q)
		&& readDirFlag_q == $past(rw))
		else $error("soft mode touched the match flag");
	a_sam_cleared: assert property (@(posedge core_clk) disable iff (!nrst)
		statusRead && !(evalGo && samSet) |=> !addressMatchFlag_q)
		else $error("status read left the match flag");
	a_byte_full: assert property (@(posedge core_clk) disable iff (!nrst)
		fifoInValid && fifoInReady |=> receiveFullFlag)
		else $error("received byte did not set full");
	a_stop_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		(startSeen || stopSeen) && addressed_q |=> stopRestartFlag_q && irq)
		else $error("stop or restart not flagged");
	a_tx_refused: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == ST_TX_ACK && sclRise && sdaS |=> refusedAckFlag_q ##0 irq)
		else $error("master refusal not flagged");
	a_dma_route: assert property (@(posedge core_clk) disable iff (!nrst)
		rxValid && dmaRoutingFlag && !addressMatchFlag_q
		&& !stopRestartFlag_q && !refusedAckFlag_q |-> dmaRequest && !irq)
		else $error("routed byte raised an interrupt");
endmodule // isd_slave

// File: tb/isd_master_model.sv
// two-wire bus master model: drives scl and sda low through open drain
`timescale 1ns/100ps
module isd_master_model
#(
	parameter real QTR = 31.25
)
(
	input  wire logic scl,
	input  wire logic sda,
	output logic      sclLow,
	output logic      sdaLow
);
	initial
	begin
		sclLow = 1'h0;
		sdaLow = 1'h0;
	end
	// =====================================================
	// bit level
	// bounded, so a slave that never lets go cannot hang us
	task automatic waitHigh();
		int n;
		n = 0;
		while (scl !== 1'h1 && n < 40000)
		begin
			#1;
			n++;
		end
	endtask
	task automatic bitClk(output logic v);
		#QTR sclLow = 1'h0;
		waitHigh();
		#QTR v = sda;
		#QTR sclLow = 1'h1;
		#QTR;
	endtask
	// =====================================================
	// frame level
	task automatic startCond();
		sdaLow = 1'h0;
		sclLow = 1'h0;
		#(2*QTR) sdaLow = 1'h1;
		#QTR sclLow = 1'h1;
		#QTR;
	endtask
	task automatic stopCond();
		sdaLow = 1'h1;
		#QTR sclLow = 1'h0;
		waitHigh();
		#QTR sdaLow = 1'h0;
		#(2*QTR);
	endtask
	task automatic wrByte(input logic [7:0] b, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--)
		begin
			sdaLow = !b[i];
			bitClk(v);
		end
		sdaLow = 1'h0;
		bitClk(v);
		ack = !v;
	endtask
	task automatic rdByte(input logic nak, output logic [7:0] b);
		logic v;
		sdaLow = 1'h0;
		for (int i = 7; i >= 0; i--)
			bitClk(b[i]);
		sdaLow = !nak;
		bitClk(v);
	endtask
endmodule // isd_master_model

// File: tb/test_isd_slave.sv
// self-checking bench for the two-wire slave controller
`timescale 1ns/100ps
module test_isd_slave;
	import isd_pkg::*;
	logic      core_clk, nrst, sclIn, sdaIn, sclOut, sclOe, sdaOut, sdaOe;
	logic      controllerEnable, tenBitMode, softwareRecognitionSelect;
	logic      generalCallEnable, dmaRoutingFlag, refuseAck, controlWrite;
	logic      statusRead, dataRead, receiveFullFlag, dmaRequest, txValid;
	logic      txReady, addressMatchFlag, generalCallFlag, readDirFlag;
	logic      stopRestartFlag, refusedAckFlag, irq, mScl, mSda, ack;
	isd_addr_t ownAddressField;
	isd_byte_t rxData, txData, rb;
	int        err_total, n_checks;
	// open-drain wires with pull-ups
	assign sclIn = !((sclOe & ~sclOut) | mScl);
	assign sdaIn = !((sdaOe & ~sdaOut) | mSda);
	isd_slave isd_slave_i (.core_clk, .nrst, .sclIn, .sclOut, .sclOe,
		.sdaIn, .sdaOut, .sdaOe, .controllerEnable, .tenBitMode,
		.softwareRecognitionSelect, .generalCallEnable, .dmaRoutingFlag,
		.refuseAck, .ownAddressField, .controlWrite, .statusRead, .rxData,
		.receiveFullFlag, .dataRead, .dmaRequest, .txData, .txValid,
		.txReady, .addressMatchFlag, .generalCallFlag, .readDirFlag,
		.stopRestartFlag, .refusedAckFlag, .irq);
	isd_master_model isd_master_model_i (.scl(sclIn), .sda(sdaIn),
		.sclLow(mScl), .sdaLow(mSda));
	initial
	begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	// =====================================================
	// helpers
	task automatic chk1(input logic g, input logic e, input string m);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %0t %s got %b", $time, m, g);
		end
	endtask
	task automatic chk8(input isd_byte_t g, input isd_byte_t e,
		input string m);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %0t %s got %h", $time, m, g);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", err_total, n_checks);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// k: 0 status read, 1 data read, 2 control write
	task automatic pulse(input int k);
		tick(1);
		statusRead = (k == 0);
		dataRead = (k == 1);
		controlWrite = (k == 2);
		tick(1);
		{statusRead, dataRead, controlWrite} = 3'h0;
	endtask
	task automatic sendAddr(input isd_byte_t b, input logic e);
		isd_master_model_i.startCond();
		isd_master_model_i.wrByte(b, ack);
		chk1(ack, e, "address ack");
	endtask
	task automatic closeTx();
		isd_master_model_i.stopCond();
		tick(4);
		pulse(0);
	endtask
	// =====================================================
	// scenarios
	task automatic t_rx();
		sendAddr(8'hB6, 1'h0);
		chk1(addressMatchFlag, 1'h0, "foreign");
		closeTx();
		sendAddr(8'hB4, 1'h1);
		chk1(addressMatchFlag, 1'h1, "match");
		chk1(readDirFlag, 1'h0, "dir");
		chk1(irq, 1'h1, "irq");
		pulse(0);
		chk1(addressMatchFlag, 1'h0, "match clr");
		isd_master_model_i.wrByte(8'hA5, ack);
		chk1(ack, 1'h1, "data ack");
		chk1(receiveFullFlag, 1'h1, "full");
		chk8(rxData, 8'hA5, "rx");
		pulse(1);
		chk1(receiveFullFlag, 1'h0, "full clr");
		refuseAck = 1'h1;
		isd_master_model_i.wrByte(8'h3C, ack);
		chk1(ack, 1'h0, "data nak");
		pulse(1);
		isd_master_model_i.stopCond();
		tick(4);
		chk1(stopRestartFlag, 1'h1, "stop");
		pulse(0);
		refuseAck = 1'h0;
	endtask
	task automatic t_gc();
		generalCallEnable = 1'h1;
		sendAddr(8'h00, 1'h1);
		chk1(generalCallFlag, 1'h1, "gc");
		chk1(addressMatchFlag, 1'h1, "gc match");
		chk1(readDirFlag, 1'h0, "gc dir");
		tick(1);
		softwareRecognitionSelect = 1'h1;
		fork
			isd_master_model_i.wrByte(8'h5C, ack);
			begin
				wait (receiveFullFlag === 1'h1);
				tick(8);
				chk1(sclIn, 1'h0, "gc stretch");
				chk8(rxData, 8'h5C, "gc data");
				pulse(1);
				pulse(2);
			end
		join
		chk1(ack, 1'h1, "gc data ack");
		closeTx();
		softwareRecognitionSelect = 1'h0;
		sendAddr(8'h01, 1'h0);
		chk1(generalCallFlag, 1'h1, "sb");
		chk1(readDirFlag, 1'h1, "sb dir");
		closeTx();
		generalCallEnable = 1'h0;
		sendAddr(8'h00, 1'h0);
		chk1(generalCallFlag, 1'h0, "gc off");
		closeTx();
	endtask
	task automatic t_ten();
		tenBitMode = 1'h1;
		ownAddressField = 10'h2B5;
		sendAddr(8'hF4, 1'h1);
		isd_master_model_i.wrByte(8'hB5, ack);
		chk1(ack, 1'h1, "ten ack");
		chk1(addressMatchFlag, 1'h1, "ten match");
		closeTx();
		sendAddr(8'hF4, 1'h1);
		isd_master_model_i.wrByte(8'hB4, ack);
		chk1(ack, 1'h0, "ten miss");
		chk1(addressMatchFlag, 1'h0, "ten nomatch");
		closeTx();
		tenBitMode = 1'h0;
		ownAddressField = 10'h05A;
	endtask
	task automatic t_soft();
		softwareRecognitionSelect = 1'h1;
		isd_master_model_i.startCond();
		fork
			isd_master_model_i.wrByte(8'hAB, ack);
			begin
				wait (receiveFullFlag === 1'h1);
				tick(8);
				chk1(sclIn, 1'h0, "stretch");
				chk8(rxData, 8'hAB, "soft rx");
				chk1(irq, 1'h1, "soft irq");
				chk1(addressMatchFlag, 1'h0, "soft match");
				pulse(1);
				// refusing keeps a read address off the transmit path
				refuseAck = 1'h1;
				pulse(2);
				chk1(readDirFlag, 1'h1, "soft dir");
			end
		join
		chk1(ack, 1'h0, "soft nak");
		closeTx();
		softwareRecognitionSelect = 1'h0;
		refuseAck = 1'h0;
	endtask
	task automatic t_dma();
		sendAddr(8'hB4, 1'h1);
		pulse(0);
		dmaRoutingFlag = 1'h1;
		for (int i = 0; i < 8; i++)
			isd_master_model_i.wrByte(8'h10 + i[7:0], ack);
		chk1(dmaRequest, 1'h1, "dma req");
		chk1(irq, 1'h0, "no rx irq");
		tick(1);
		refuseAck = 1'h1;
		fork
			isd_master_model_i.wrByte(8'h18, ack);
			begin
				tick(200);
				chk1(sclIn, 1'h0, "full stretch");
				for (int i = 0; i < 9; i++)
				begin
					wait (receiveFullFlag === 1'h1);
					chk8(rxData, 8'h10 + i[7:0], "dma data");
					pulse(1);
				end
			end
		join
		chk1(ack, 1'h0, "last nak");
		chk1(dmaRequest, 1'h0, "dma idle");
		closeTx();
		dmaRoutingFlag = 1'h0;
		refuseAck = 1'h0;
	endtask
	task automatic t_tx();
		sendAddr(8'hB5, 1'h1);
		chk1(readDirFlag, 1'h1, "rd dir");
		tick(8);
		chk1(txReady, 1'h1, "tx ready");
		chk1(sclIn, 1'h0, "tx stretch");
		txData = 8'h3C;
		txValid = 1'h1;
		isd_master_model_i.rdByte(1'h1, rb);
		chk8(rb, 8'h3C, "tx byte");
		chk1(refusedAckFlag, 1'h1, "refused");
		closeTx();
		txValid = 1'h0;
	endtask
	// =====================================================
	// main sequence and watchdog
	initial
	begin
		{nrst, controllerEnable, tenBitMode, controlWrite} = 4'h0;
		{generalCallEnable, dmaRoutingFlag, refuseAck} = 3'h0;
		{statusRead, dataRead, txValid, softwareRecognitionSelect} = 4'h0;
		ownAddressField = 10'h05A;
		txData = 8'h00;
		err_total = 0;
		n_checks = 0;
		tick(8);
		nrst = 1'h1;
		controllerEnable = 1'h1;
		tick(4);
		t_rx();
		t_gc();
		t_ten();
		t_soft();
		t_dma();
		t_tx();
		end_of_test();
	end
	initial
	begin
		#300000;
		err_total++;
		end_of_test();
	end
endmodule // test_isd_slave
